/* src/drive_defines.svh */
`ifndef DRIVE_DEFINES_SVH
`define DRIVE_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS     4
`define RAMP_TICK_NS       1000000

// ----------------------------------------------------------------
// Object indices
// ----------------------------------------------------------------
`define OBJ_CONTROLWORD    16'h6040
`define OBJ_STATUSWORD     16'h6041
`define OBJ_TARGET_SPEED   16'h6042
`define OBJ_ACTUAL_SPEED   16'h6043
`define OBJ_ACCEL          16'h604f
`define OBJ_DECEL          16'h6050
`define OBJ_QUICK_STOP_OPT 16'h605a
`define OBJ_DISABLE_OP_OPT 16'h605c
`define OBJ_MODE           16'h6060
`define OBJ_QUICK_DECEL    16'h6085

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define QS_OPT_RESET       16'h0002
`define DIS_OPT_RESET      16'h0001
`define ACCEL_RESET        16'h0001
`define DECEL_RESET        16'h0001
`define QDECEL_RESET       16'h0004
`define PROFILE_STANDARD   2'h1
`define OP_SOURCE_BUS      4'h3
`define FREQ_SOURCE_BUS    4'h6
`define MI_FUNC_QUICK_STOP 8'h35
`define MODE_VELOCITY      8'h02
`define VEL_HOLD           3'h5
`define VEL_RUN            3'h7
`define SPEED_DIVISOR      25'sh0000078

// ----------------------------------------------------------------
// Controlword bits
// ----------------------------------------------------------------
`define CW_SWITCH_ON       0
`define CW_ENABLE_VOLT     1
`define CW_QUICK_STOP      2
`define CW_ENABLE_OP       3
`define CW_MODE_LO         4
`define CW_MODE_HI         6
`define CW_FAULT_RESET     7
`define CW_HALT            8

// ----------------------------------------------------------------
// Statusword images
// ----------------------------------------------------------------
`define SW_NOT_READY       16'h0000
`define SW_SW_ON_DISABLED  16'h0040
`define SW_READY           16'h0021
`define SW_SWITCHED_ON     16'h0023
`define SW_OP_ENABLED      16'h0027
`define SW_QUICK_STOP      16'h0007
`define SW_FAULT_REACTION  16'h000f
`define SW_FAULT           16'h0008
`define SW_REACHED_BIT     10

// ----------------------------------------------------------------
// Master script values
// ----------------------------------------------------------------
`define CW_SHUTDOWN        16'h000e
`define CW_ENABLE          16'h000f
`define CW_RUN             16'h007f
`define SCRIPT_LEN         3'h5

`endif

/* src/drive_pkg.sv */
package drive_pkg;

  typedef enum logic [3:0]
  {
    ST_START         = 4'h0,
    ST_NOT_READY     = 4'h1,
    ST_SW_ON_DISABLE = 4'h2,
    ST_READY         = 4'h3,
    ST_SWITCHED_ON   = 4'h4,
    ST_OP_ENABLED    = 4'h5,
    ST_QUICK_STOP    = 4'h6,
    ST_FAULT_REACT   = 4'h7,
    ST_FAULT         = 4'h8
  } drive_state_t;

  typedef enum logic [1:0]
  {
    M_IDLE  = 2'h0,
    M_ISSUE = 2'h1,
    M_WAIT  = 2'h2
  } master_state_t;

endpackage

/* src/od_link_if.sv */
interface od_link_if;
  logic        req;
  logic        we;
  logic [15:0] index;
  logic [15:0] wdata;
  logic        ack;
  logic        err;
  logic [15:0] rdata;

  modport device
  (
    input  req,
    input  we,
    input  index,
    input  wdata,
    output ack,
    output err,
    output rdata
  );

  modport master
  (
    output req,
    output we,
    output index,
    output wdata,
    input  ack,
    input  err,
    input  rdata
  );
endinterface

/* src/drive_device.sv */
// Operation
// - Operation source must be 3 for bus
// - Frequency source must be 6 for bus
// - Profile 1 enables standard state machine
// - Decode bit-rate codes 0..5
// - Input function 53 requests quick stop
// - Power-disabled, power-enabled and fault blocks
// - Nine drive states
// - Wait after init for controlword commands
// - Switched on: PWM, reference ignored
// - Decode controlword bits
// - Master writes 0xE then 0xF
// - Quick stop return only for option 1..3
// - Quick stop option code behaviour
// - Disable operation option code behaviour
// - Disable option applies leaving power-enabled
// - Master writes mode 2 first
// - Signed rpm target, freq = rpm*poles/120
// - Ramps from acceleration and deceleration objects
// - Velocity bits 6..4: hold, run, stop
// - Actual speed readable in rpm
// - Quick stop request enters quick stop
`include "drive_defines.svh"

module drive_device #(
  parameter int RAMP_TICK = `RAMP_TICK_NS / `MCLK_PERIOD_NS
)(
  input  wire logic         mclk,
  input  wire logic         reset,
  od_link_if.device         od,
  input  wire logic [1:0]   profile_select,
  input  wire logic [3:0]   operation_source_select,
  input  wire logic [3:0]   frequency_source_select,
  input  wire logic [2:0]   bus_bitrate_select,
  input  wire logic [7:0]   motor_pole_count,
  input  wire logic [7:0]   multifunction_input_func,
  input  wire logic         multifunction_input,
  input  wire logic         init_done,
  input  wire logic         error_active,
  output logic              pwm_enable,
  output logic signed [15:0] output_freq_hz,
  output logic [10:0]       bitrate_kbps,
  output logic [3:0]        drive_state
);

  generate
    if (RAMP_TICK < 1)
    begin : g_check
      $error("RAMP_TICK must be at least one cycle");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] bitrate_of(input logic [2:0] code);
    case (code)
      3'h0:    bitrate_of = 11'h3e8;
      3'h1:    bitrate_of = 11'h1f4;
      3'h2:    bitrate_of = 11'h0fa;
      3'h3:    bitrate_of = 11'h07d;
      3'h4:    bitrate_of = 11'h064;
      3'h5:    bitrate_of = 11'h032;
      default: bitrate_of = 11'h000;
    endcase
  endfunction

  // Moves cur toward goal; up rate while magnitude grows, dn otherwise
  function automatic logic signed [15:0] ramp_step(input logic signed [15:0] cur,
                                                   input logic signed [15:0] goal,
                                                   input logic [15:0]        up,
                                                   input logic [15:0]        dn);
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic               grow;
    diff = 17'(goal) - 17'(cur);
    grow = (cur >= 0 && diff > 0) || (cur <= 0 && diff < 0);
    step = grow ? $signed({1'b0, up}) : $signed({1'b0, dn});
    if (diff <= step && diff >= -step)
      ramp_step = goal;
    else if (diff > 0)
      ramp_step = 16'(17'(cur) + step);
    else
      ramp_step = 16'(17'(cur) - step);
  endfunction

  function automatic logic [15:0] status_of(input drive_pkg::drive_state_t s);
    case (s)
      drive_pkg::ST_SW_ON_DISABLE: status_of = `SW_SW_ON_DISABLED;
      drive_pkg::ST_READY:         status_of = `SW_READY;
      drive_pkg::ST_SWITCHED_ON:   status_of = `SW_SWITCHED_ON;
      drive_pkg::ST_OP_ENABLED:    status_of = `SW_OP_ENABLED;
      drive_pkg::ST_QUICK_STOP:    status_of = `SW_QUICK_STOP;
      drive_pkg::ST_FAULT_REACT:   status_of = `SW_FAULT_REACTION;
      drive_pkg::ST_FAULT:         status_of = `SW_FAULT;
      default:                     status_of = `SW_NOT_READY;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Object registers
  // ----------------------------------------------------------------
  logic [15:0]               controlword;
  logic [7:0]                mode;
  logic signed [15:0]        target_rpm;
  logic [15:0]               accel;
  logic [15:0]               decel;
  logic [15:0]               quick_decel;
  logic signed [15:0]        quick_stop_option;
  logic signed [15:0]        disable_operation_option;
  logic signed [15:0]        actual_rpm;
  logic                      reached;
  drive_pkg::drive_state_t   state;
  drive_pkg::drive_state_t   next_state;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      controlword              <= 16'h0000;
      mode                     <= 8'h00;
      target_rpm               <= 16'sh0000;
      accel                    <= `ACCEL_RESET;
      decel                    <= `DECEL_RESET;
      quick_decel              <= `QDECEL_RESET;
      quick_stop_option        <= `QS_OPT_RESET;
      disable_operation_option <= `DIS_OPT_RESET;
    end
    else if (od.req && od.we)
    begin
      case (od.index)
        `OBJ_CONTROLWORD:    controlword <= od.wdata;
        `OBJ_MODE:           mode <= od.wdata[7:0];
        `OBJ_TARGET_SPEED:   target_rpm <= od.wdata;
        `OBJ_ACCEL:          accel <= od.wdata;
        `OBJ_DECEL:          decel <= od.wdata;
        `OBJ_QUICK_DECEL:    quick_decel <= od.wdata;
        `OBJ_QUICK_STOP_OPT: quick_stop_option <= od.wdata;
        `OBJ_DISABLE_OP_OPT: disable_operation_option <= od.wdata;
        default:             ;
      endcase
    end
  end

  // Read answer one cycle after the request; unknown index flags err
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      od.ack   <= 1'b0;
      od.err   <= 1'b0;
      od.rdata <= 16'h0000;
    end
    else
    begin
      od.ack   <= od.req;
      od.err   <= 1'b0;
      od.rdata <= 16'h0000;
      if (od.req)
      begin
        case (od.index)
          `OBJ_CONTROLWORD:    od.rdata <= controlword;
          `OBJ_STATUSWORD:     od.rdata <= status_of(state) | (16'(reached) << `SW_REACHED_BIT);
          `OBJ_MODE:           od.rdata <= {8'h00, mode};
          `OBJ_TARGET_SPEED:   od.rdata <= target_rpm;
          `OBJ_ACTUAL_SPEED:   od.rdata <= actual_rpm;
          `OBJ_ACCEL:          od.rdata <= accel;
          `OBJ_DECEL:          od.rdata <= decel;
          `OBJ_QUICK_DECEL:    od.rdata <= quick_decel;
          `OBJ_QUICK_STOP_OPT: od.rdata <= quick_stop_option;
          `OBJ_DISABLE_OP_OPT: od.rdata <= disable_operation_option;
          default:             od.err <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic mi_meta;
  logic mi_sync;
  logic reset_prev;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mi_meta    <= 1'b0;
      mi_sync    <= 1'b0;
      reset_prev <= 1'b0;
    end
    else
    begin
      mi_meta    <= multifunction_input;
      mi_sync    <= mi_meta;
      reset_prev <= controlword[`CW_FAULT_RESET];
    end
  end

  logic cmd_ok;
  logic shutdown;
  logic switch_on;
  logic enable_op;
  logic no_voltage;
  logic qs_request;
  logic fault_reset;
  logic qs_may_return;
  logic qs_ramp_only;

  assign cmd_ok      = (profile_select == `PROFILE_STANDARD)
                    && (operation_source_select == `OP_SOURCE_BUS);
  assign shutdown    = controlword[`CW_ENABLE_VOLT] && controlword[`CW_QUICK_STOP]
                    && !controlword[`CW_SWITCH_ON];
  assign switch_on   = controlword[`CW_ENABLE_VOLT] && controlword[`CW_QUICK_STOP]
                    && controlword[`CW_SWITCH_ON] && !controlword[`CW_ENABLE_OP];
  assign enable_op   = controlword[`CW_ENABLE_VOLT] && controlword[`CW_QUICK_STOP]
                    && controlword[`CW_SWITCH_ON] && controlword[`CW_ENABLE_OP];
  assign no_voltage  = !controlword[`CW_ENABLE_VOLT];
  assign qs_request  = (controlword[`CW_ENABLE_VOLT] && !controlword[`CW_QUICK_STOP])
                    || (mi_sync && multifunction_input_func == `MI_FUNC_QUICK_STOP);
  assign fault_reset = controlword[`CW_FAULT_RESET] && !reset_prev;
  assign qs_may_return = quick_stop_option >= 16'sh0001
                      && quick_stop_option <= 16'sh0003;
  assign qs_ramp_only  = quick_stop_option == 16'sh0001
                      || quick_stop_option == 16'sh0002;

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      drive_pkg::ST_START:       next_state = drive_pkg::ST_NOT_READY;
      drive_pkg::ST_NOT_READY:
        if (init_done) next_state = drive_pkg::ST_SW_ON_DISABLE;
      drive_pkg::ST_SW_ON_DISABLE:
        if (cmd_ok && shutdown) next_state = drive_pkg::ST_READY;
      drive_pkg::ST_READY:
        if (cmd_ok && (no_voltage || qs_request)) next_state = drive_pkg::ST_SW_ON_DISABLE;
        else if (cmd_ok && switch_on) next_state = drive_pkg::ST_SWITCHED_ON;
        else if (cmd_ok && enable_op) next_state = drive_pkg::ST_OP_ENABLED;
      drive_pkg::ST_SWITCHED_ON:
        if (cmd_ok && (no_voltage || qs_request)) next_state = drive_pkg::ST_SW_ON_DISABLE;
        else if (cmd_ok && shutdown) next_state = drive_pkg::ST_READY;
        else if (cmd_ok && enable_op) next_state = drive_pkg::ST_OP_ENABLED;
      drive_pkg::ST_OP_ENABLED:
        if (cmd_ok && no_voltage) next_state = drive_pkg::ST_SW_ON_DISABLE;
        else if (cmd_ok && qs_request) next_state = drive_pkg::ST_QUICK_STOP;
        else if (cmd_ok && shutdown) next_state = drive_pkg::ST_READY;
        else if (cmd_ok && switch_on) next_state = drive_pkg::ST_SWITCHED_ON;
      drive_pkg::ST_QUICK_STOP:
        if (quick_stop_option == 16'sh0000 || (cmd_ok && no_voltage))
          next_state = drive_pkg::ST_SW_ON_DISABLE;
        else if (cmd_ok && enable_op && qs_may_return && !qs_request)
          next_state = drive_pkg::ST_OP_ENABLED;
        else if (qs_ramp_only && actual_rpm == 16'sh0000)
          next_state = drive_pkg::ST_SW_ON_DISABLE;
      drive_pkg::ST_FAULT_REACT:
        if (actual_rpm == 16'sh0000) next_state = drive_pkg::ST_FAULT;
      drive_pkg::ST_FAULT:
        if (fault_reset && !error_active) next_state = drive_pkg::ST_SW_ON_DISABLE;
      default:                   next_state = drive_pkg::ST_START;
    endcase
    // Fault reaction keeps its own exit once the speed is zero
    if (error_active && state != drive_pkg::ST_FAULT && state != drive_pkg::ST_START
        && state != drive_pkg::ST_FAULT_REACT)
      next_state = drive_pkg::ST_FAULT_REACT;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      state <= drive_pkg::ST_START;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Power blocks and stopping
  // ----------------------------------------------------------------
  logic powered;
  logic next_powered;
  logic stopping;

  assign powered      = state == drive_pkg::ST_SWITCHED_ON || state == drive_pkg::ST_OP_ENABLED
                     || state == drive_pkg::ST_QUICK_STOP || state == drive_pkg::ST_FAULT_REACT;
  assign next_powered = next_state == drive_pkg::ST_SWITCHED_ON
                     || next_state == drive_pkg::ST_OP_ENABLED
                     || next_state == drive_pkg::ST_QUICK_STOP
                     || next_state == drive_pkg::ST_FAULT_REACT;
  assign pwm_enable   = powered || stopping;

  // Option 1 keeps PWM alive on the normal ramp; option 0 cuts at once
  always_ff @(posedge mclk)
  begin
    if (reset)
      stopping <= 1'b0;
    else if (powered && !next_powered && state != drive_pkg::ST_QUICK_STOP
             && disable_operation_option == 16'sh0001)
      stopping <= actual_rpm != 16'sh0000;
    else if (actual_rpm == 16'sh0000 || next_powered)
      stopping <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Speed ramp
  // ----------------------------------------------------------------
  logic signed [15:0] goal;
  logic [15:0]        down_rate;
  logic [31:0]        tick_cnt;

  always_comb
  begin
    goal      = 16'sh0000;
    down_rate = decel;
    case (state)
      drive_pkg::ST_OP_ENABLED:
        if (!controlword[`CW_HALT] && mode == `MODE_VELOCITY
            && frequency_source_select == `FREQ_SOURCE_BUS)
        begin
          case (controlword[`CW_MODE_HI:`CW_MODE_LO])
            `VEL_HOLD: goal = actual_rpm;
            `VEL_RUN:  goal = target_rpm;
            default:   goal = 16'sh0000;
          endcase
        end
      drive_pkg::ST_QUICK_STOP:
        if (quick_stop_option != 16'sh0001 && quick_stop_option != 16'sh0005)
          down_rate = quick_decel;
      drive_pkg::ST_FAULT_REACT: down_rate = quick_decel;
      default:                   goal = 16'sh0000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset || tick_cnt == 32'(RAMP_TICK - 1))
      tick_cnt <= 32'h0000_0000;
    else
      tick_cnt <= tick_cnt + 32'h0000_0001;
  end

  always_ff @(posedge mclk)
  begin
    if (reset || !pwm_enable)
      actual_rpm <= 16'sh0000;
    else if (tick_cnt == 32'(RAMP_TICK - 1))
      actual_rpm <= ramp_step(actual_rpm, goal, accel, down_rate);
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      reached        <= 1'b0;
      output_freq_hz <= 16'sh0000;
      bitrate_kbps   <= 11'h000;
      drive_state    <= 4'h0;
    end
    else
    begin
      // From next_state so bit 10 never pairs with a stale state image
      reached        <= next_state == drive_pkg::ST_OP_ENABLED
                        && actual_rpm == target_rpm;
      output_freq_hz <= 16'(($signed(25'(actual_rpm)) * $signed({17'h00000, motor_pole_count}))
                            / `SPEED_DIVISOR);
      bitrate_kbps   <= bitrate_of(bus_bitrate_select);
      drive_state    <= state;
    end
  end

endmodule

/* src/drive_master.sv */
`include "drive_defines.svh"

module drive_master (
  input  wire logic        mclk,
  input  wire logic        reset,
  od_link_if.master        od,
  input  wire logic        start,
  input  wire logic signed [15:0] target_rpm,
  input  wire logic        acc_req,
  input  wire logic        acc_we,
  input  wire logic [15:0] acc_index,
  input  wire logic [15:0] acc_wdata,
  output logic             busy,
  output logic             done,
  output logic             acc_err,
  output logic [15:0]      acc_rdata
);

  // ----------------------------------------------------------------
  // Start script: mode, target, then the enable pair and run
  // ----------------------------------------------------------------
  function automatic logic [31:0] script(input logic [2:0] i,
                                         input logic [15:0] tgt);
    case (i)
      3'h0:    script = {`OBJ_MODE, 8'h00, `MODE_VELOCITY};
      3'h1:    script = {`OBJ_TARGET_SPEED, tgt};
      3'h2:    script = {`OBJ_CONTROLWORD, `CW_SHUTDOWN};
      3'h3:    script = {`OBJ_CONTROLWORD, `CW_ENABLE};
      default: script = {`OBJ_CONTROLWORD, `CW_RUN};
    endcase
  endfunction

  drive_pkg::master_state_t mstate;
  logic [2:0]               step;
  logic                     scripted;
  logic [15:0]              tgt_hold;

  assign busy = mstate != drive_pkg::M_IDLE;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mstate    <= drive_pkg::M_IDLE;
      step      <= 3'h0;
      scripted  <= 1'b0;
      tgt_hold  <= 16'h0000;
      od.req    <= 1'b0;
      od.we     <= 1'b0;
      od.index  <= 16'h0000;
      od.wdata  <= 16'h0000;
      done      <= 1'b0;
      acc_err   <= 1'b0;
      acc_rdata <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      case (mstate)
        drive_pkg::M_IDLE:
          if (start)
          begin
            scripted <= 1'b1;
            step     <= 3'h0;
            tgt_hold <= target_rpm;
            mstate   <= drive_pkg::M_ISSUE;
          end
          else if (acc_req)
          begin
            scripted <= 1'b0;
            od.req   <= 1'b1;
            od.we    <= acc_we;
            od.index <= acc_index;
            od.wdata <= acc_wdata;
            mstate   <= drive_pkg::M_WAIT;
          end
        drive_pkg::M_ISSUE:
        begin
          od.req   <= 1'b1;
          od.we    <= 1'b1;
          {od.index, od.wdata} <= script(step, tgt_hold);
          mstate   <= drive_pkg::M_WAIT;
        end
        drive_pkg::M_WAIT:
        begin
          od.req <= 1'b0;
          if (od.ack)
          begin
            acc_err   <= od.err;
            acc_rdata <= od.rdata;
            if (scripted && step != `SCRIPT_LEN - 3'h1)
            begin
              step   <= step + 3'h1;
              mstate <= drive_pkg::M_ISSUE;
            end
            else
            begin
              done   <= 1'b1;
              mstate <= drive_pkg::M_IDLE;
            end
          end
        end
        default: mstate <= drive_pkg::M_IDLE;
      endcase
    end
  end

endmodule

/* sim/drive_link_monitor.sv */
module drive_link_monitor (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] index,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic        err,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic known;

  assign known = index inside {16'h6040, 16'h6041, 16'h6042, 16'h6043, 16'h604f, 16'h6050,
                               16'h605a, 16'h605c, 16'h6060, 16'h6085};
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_rd(logic [15:0] i);
    req && !we && index == i;
  endsequence

  a_ack_next: assert property (req |=> ack)
    else $error("request not answered");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("answer without request");
  a_unknown_err: assert property (req && !known |=> err && rdata == 16'h0000)
    else $error("unknown object not flagged");
  a_known_ok: assert property (req && known |=> !err)
    else $error("known object flagged");
  a_sw_image: assert property (s_rd(16'h6041) |=> rdata[6:0] inside
    {7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07, 7'h0f, 7'h08}) else $error("bad state image");
  a_reached_oe: assert property (s_rd(16'h6041) |=> !rdata[10] || rdata[6:0] == 7'h27)
    else $error("reached outside operation");
  a_speed_read: assert property (s_rd(16'h6043) |=> ack && !err)
    else $error("speed read refused");
  a_req_spaced: assert property (req |=> !req [*2])
    else $error("requests too close");
endmodule

/* sim/drive_profile_state_machine_tb_top.sv */
module drive_profile_state_machine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               mclk = 1'b0;
  logic               reset = 1'b1;
  logic [2:0]         rate_code = 3'h0;
  logic [7:0]         mi_func = 8'h00;
  logic               mi = 1'b0;
  logic               fault_in = 1'b0;
  logic [1:0]         profile = 2'h1;
  logic               init_ok = 1'b0;
  logic               start = 1'b0;
  logic signed [15:0] target_rpm = 16'sh0000;
  logic               acc_req = 1'b0;
  logic               acc_we = 1'b0;
  logic [15:0]        acc_index = 16'h0000;
  logic [15:0]        acc_wdata = 16'h0000;
  logic               busy, done, acc_err, pwm_enable;
  logic [15:0]        acc_rdata;
  logic signed [15:0] output_freq_hz;
  logic [10:0]        bitrate_kbps;
  logic [3:0]         drive_state;
  int                 err_total = 0;
  int                 total_checks = 0;

  always #2 mclk = ~mclk;
  od_link_if i_od_link_if ();
  drive_device #(.RAMP_TICK(4)) i_drive_device (.mclk(mclk), .reset(reset),
    .od(i_od_link_if.device), .profile_select(profile),
    .operation_source_select(4'h3), .frequency_source_select(4'h6),
    .bus_bitrate_select(rate_code),
    .motor_pole_count(8'h04), .multifunction_input_func(mi_func), .multifunction_input(mi),
    .init_done(init_ok), .error_active(fault_in), .pwm_enable(pwm_enable),
    .output_freq_hz(output_freq_hz), .bitrate_kbps(bitrate_kbps), .drive_state(drive_state));
  drive_master i_drive_master (.mclk(mclk), .reset(reset), .od(i_od_link_if.master),
    .start(start), .target_rpm(target_rpm), .acc_req(acc_req), .acc_we(acc_we),
    .acc_index(acc_index), .acc_wdata(acc_wdata), .busy(busy), .done(done),
    .acc_err(acc_err), .acc_rdata(acc_rdata));
  drive_link_monitor i_drive_link_monitor (.mclk(mclk), .reset(reset),
    .req(i_od_link_if.req), .we(i_od_link_if.we), .index(i_od_link_if.index),
    .wdata(i_od_link_if.wdata), .ack(i_od_link_if.ack), .err(i_od_link_if.err),
    .rdata(i_od_link_if.rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Bounded wait for done or for a given state
  task automatic wait_for(input int lim, input logic [3:0] st, input logic on_done);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while ((on_done ? done !== 1'b1 : drive_state !== st) && n < lim);
    if (on_done ? done !== 1'b1 : drive_state !== st)
    begin
      err_total++;
      $display("MISMATCH %0t wait ran out", $time);
      tally_and_finish();
    end
  endtask

  task automatic access(input logic w, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge mclk);
    acc_req <= 1'b1;
    acc_we <= w;
    acc_index <= idx;
    acc_wdata <= wd;
    @(posedge mclk);
    acc_req <= 1'b0;
    wait_for(20, 4'h0, 1'b1);
  endtask

  task automatic t_options();
    access(1'b0, 16'h605a, 16'h0000);
    chk(acc_rdata, 16'h0002);
    access(1'b0, 16'h605c, 16'h0000);
    chk(acc_rdata, 16'h0001);
    access(1'b1, 16'h605a, 16'h0005);
    access(1'b0, 16'h605a, 16'h0000);
    chk(acc_rdata, 16'h0005);
    access(1'b1, 16'h605a, 16'h0002);
    access(1'b0, 16'h7000, 16'h0000);
    chk(16'(acc_err), 16'h0001);
    @(posedge mclk);
    profile <= 2'h0;
    access(1'b1, 16'h6040, 16'h000e);
    access(1'b0, 16'h6041, 16'h0000);
    chk(acc_rdata, 16'h0040);
    access(1'b1, 16'h6040, 16'h0000);
    @(posedge mclk);
    profile <= 2'h1;
    access(1'b0, 16'h6041, 16'h0000);
    chk(acc_rdata, 16'h0040);
  endtask

  task automatic t_bitrate();
    logic [10:0] rate [8] = '{11'h3e8, 11'h1f4, 11'h0fa, 11'h07d, 11'h064, 11'h032, 11'h000,
                              11'h000};
    for (int c = 0; c < 8; c++)
    begin
      @(posedge mclk);
      rate_code <= 3'(c);
      repeat (3) @(posedge mclk);
      #1 chk(16'(bitrate_kbps), 16'(rate[c]));
    end
  endtask

  task automatic t_run();
    access(1'b1, 16'h604f, 16'h01f4);
    @(posedge mclk);
    start <= 1'b1;
    target_rpm <= 16'sh05dc;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    chk(16'(busy), 16'h0001);
    wait_for(60, 4'h0, 1'b1);
    chk(16'(drive_state), 16'h0005);
    access(1'b0, 16'h6041, 16'h0000);
    for (int n = 0; n < 40 && acc_rdata[10] !== 1'b1; n++) access(1'b0, 16'h6041, 16'h0000);
    chk(acc_rdata, 16'h0427);
    access(1'b0, 16'h6043, 16'h0000);
    chk(acc_rdata, 16'h05dc);
    chk(output_freq_hz, 16'h0032);
  endtask

  task automatic t_quick_stop();
    access(1'b1, 16'h6040, 16'h007b);
    wait_for(20, 4'h6, 1'b0);
    access(1'b1, 16'h6040, 16'h007f);
    wait_for(20, 4'h5, 1'b0);
    @(posedge mclk);
    mi_func <= 8'h35;
    mi <= 1'b1;
    wait_for(20, 4'h6, 1'b0);
    chk(16'(pwm_enable), 16'h0001);
    wait_for(3000, 4'h2, 1'b0);
    chk(16'(pwm_enable), 16'h0000);
    @(posedge mclk);
    mi <= 1'b0;
  endtask

  task automatic t_fault();
    @(posedge mclk);
    fault_in <= 1'b1;
    wait_for(20, 4'h8, 1'b0);
    access(1'b1, 16'h6040, 16'h0000);
    access(1'b1, 16'h6040, 16'h0080);
    chk(16'(drive_state), 16'h0008);
    @(posedge mclk);
    fault_in <= 1'b0;
    access(1'b1, 16'h6040, 16'h0000);
    access(1'b1, 16'h6040, 16'h0080);
    wait_for(20, 4'h2, 1'b0);
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(negedge mclk);
    chk(16'(drive_state), 16'h0001);
    @(posedge mclk);
    init_ok <= 1'b1;
    wait_for(20, 4'h2, 1'b0);
    t_options();
    t_bitrate();
    t_run();
    t_quick_stop();
    t_fault();
    tally_and_finish();
  end
endmodule
